// >>> design/acffc_pkg.sv
package acffc_pkg;
  // register indices on the byte-wide module port
  localparam logic [2:0] ACFFC_OFS_DIV  = 3'h3;
  localparam logic [2:0] ACFFC_OFS_FMT  = 3'h4;
  localparam logic [2:0] ACFFC_OFS_FLOW = 3'h5;
  // field positions
  localparam int ACFFC_FMT_JUST = 7;
  localparam int ACFFC_FLW_ABRT = 7;
  localparam int ACFFC_FLW_SEQUENCE_TRIGGER = 6;
  localparam int ACFFC_FLW_RESTART_EVENT = 5;
  localparam int ACFFC_FLW_LIST_LOAD_OK = 4;
  // reset values
  localparam logic [6:0] ACFFC_PRS_RST  = 7'h00;
  localparam logic [2:0] ACFFC_RES_RST  = 3'h0;
  // resolution codes
  localparam logic [2:0] ACFFC_RES_8    = 3'h0;
  localparam logic [2:0] ACFFC_RES_10   = 3'h2;
  localparam logic [2:0] ACFFC_RES_12   = 3'h4;
  // access configuration: data bus or internal request lines
  localparam logic [1:0] ACFFC_ACC_BUS  = 2'h2;
  localparam logic [1:0] ACFFC_ACC_INT  = 2'h1;
  // timing counts in bus clocks (20 MHz bus), except ACFFC_PUMP_CC in conversion clocks
  localparam logic [1:0] ACFFC_EN_LAT   = 2'h3;
  localparam logic [2:0] ACFFC_RST_BUS  = 3'h2;
  localparam logic [2:0] ACFFC_B2B_BUS  = 3'h5;
  localparam logic [2:0] ACFFC_TRG_BUS  = 3'h5;
  localparam logic [1:0] ACFFC_PUMP_CC  = 2'h2;
  typedef enum logic [2:0] {ACFFC_IDLE, ACFFC_LOAD, ACFFC_WBUS, ACFFC_WPUMP, ACFFC_CONV, ACFFC_HALT} acffc_state_e;
endpackage

// >>> design/acffc_ctrl.sv
`timescale 1ns/100ps
// Contract
// - conversion clock is bus over 2*(prescale+1)
// - prescale written only when disabled or special
// - unsigned results, left or right justified
// - codes 000,010,100 give 8,10,12 bits
// - reserved code at start flags error, halts
// - format written only when disabled or special
// - flow bits writable three clocks after enable
// - flow bits cleared on disable or soft reset
// - flow bits set only when enabled; zero ignored
// - restart mode: 2 bus + 2 conv clocks
// - back-to-back: 5 bus + 2 conv clocks
// - trigger mode: restart carries trigger, cleared together
// - trigger mode: sample 5 clocks after trigger drops
// - abort at conversion boundary, clear when idle
// - access_config routes bus or request lines
// - bus abort while set is overrun
// - abort line while set is overrun
// - restart mid-list forces abort and error flag
// - trigger starts sequence, clears at sampling
// - bus trigger while set sets error
// - line trigger while set sets error
// - restart loads first command, then clears
module acffc_ctrl
  import acffc_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  // register port
  input  wire logic [2:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // module control
  input  wire logic        conv_enable,
  input  wire logic        special_access,
  input  wire logic        soft_reset,
  input  wire logic        trigger_mode,
  input  wire logic [1:0]  access_config,
  // internal request lines
  input  wire logic        abort_request_line,
  input  wire logic        trigger_request_line,
  input  wire logic        restart_request_line,
  input  wire logic        load_ok_request_line,
  // converter core
  input  wire logic        conv_done,
  input  wire logic        end_of_list,
  input  wire logic        cmd_loaded,
  input  wire logic [11:0] raw_result,
  output logic             cmd_load_req,
  output logic             sample_start,
  output logic             conv_clk_en,
  output logic      [15:0] result_word,
  output logic             command_error_flag,
  output logic             restart_error_flag,
  output logic             trigger_error_flag,
  output logic             overrun_flag,
  output logic             converter_idle
);
  logic [6:0] clock_prescale, next_clock_prescale;
  logic [6:0] pre_cnt, next_pre_cnt;
  logic       conv_clk_en_q, next_conv_clk_en;
  logic       result_justify, next_result_justify;
  logic [2:0] resolution_select, next_resolution_select;
  logic       sequence_abort, next_sequence_abort;
  logic       sequence_trigger, next_sequence_trigger;
  logic       restart_event, next_restart_event;
  logic       list_load_ok, next_list_load_ok;
  logic [1:0] en_cnt, next_en_cnt;
  logic       cmd_err, next_cmd_err, restart_event_err, next_restart_event_err, sequence_trigger_err, next_sequence_trigger_err;
  logic       ovr, next_ovr, in_list, next_in_list, was_sequence_trigger, next_was_sequence_trigger;
  logic [2:0] bus_cnt, next_bus_cnt;
  logic [1:0] cc_cnt, next_cc_cnt;
  logic [15:0] res_q, next_res_q;
  acffc_state_e state, next_state;
  logic       cfg_ok, flow_ok, wr_flow, bus_acc, int_acc;
  logic       req_abrt, req_sequence_trigger, req_restart_event, req_list_load_ok;
  logic [11:0] res_val;
  logic [3:0]  res_bits;
  logic        res_bad;
  // internal request lines come from logic on the same clock
  always_comb begin
    cfg_ok  = !conv_enable || special_access;
    flow_ok = conv_enable && (en_cnt == ACFFC_EN_LAT);
    bus_acc = (access_config == ACFFC_ACC_BUS);
    int_acc = (access_config == ACFFC_ACC_INT);
    wr_flow = reg_wr && reg_addr == ACFFC_OFS_FLOW && bus_acc;
    req_abrt = flow_ok && ((wr_flow && reg_wdata[ACFFC_FLW_ABRT]) || (int_acc && abort_request_line));
    req_sequence_trigger = flow_ok && ((wr_flow && reg_wdata[ACFFC_FLW_SEQUENCE_TRIGGER]) || (int_acc && trigger_request_line));
    req_restart_event = flow_ok && ((wr_flow && reg_wdata[ACFFC_FLW_RESTART_EVENT]) || (int_acc && restart_request_line));
    req_list_load_ok = req_restart_event && ((wr_flow && reg_wdata[ACFFC_FLW_LIST_LOAD_OK]) || (int_acc && load_ok_request_line));
    case (resolution_select)
      ACFFC_RES_8:  res_bits = 4'h8;
      ACFFC_RES_10: res_bits = 4'ha;
      ACFFC_RES_12: res_bits = 4'hc;
      default:      res_bits = 4'h0;
    endcase
    res_bad = (res_bits == 4'h0);
    res_val = raw_result >> (5'd12 - {1'b0, res_bits});
    next_res_q = res_q;
    if (conv_done && state == ACFFC_CONV) begin
      if (result_justify)
        next_res_q = {4'h0, res_val};
      else
        next_res_q = {res_val, 4'h0} << (5'd12 - {1'b0, res_bits});
    end
  end
  // prescaler and register writes
  always_comb begin
    next_clock_prescale = clock_prescale;
    next_result_justify = result_justify;
    next_resolution_select = resolution_select;
    if (reg_wr && cfg_ok && reg_addr == ACFFC_OFS_DIV)
      next_clock_prescale = reg_wdata[6:0];
    if (reg_wr && cfg_ok && reg_addr == ACFFC_OFS_FMT) begin
      next_result_justify = reg_wdata[ACFFC_FMT_JUST];
      next_resolution_select = reg_wdata[2:0];
    end
    // divide by 2*(prs+1): pulse every prs+1 half periods pair
    next_pre_cnt = pre_cnt + 7'h1;
    if (pre_cnt >= clock_prescale) begin
      next_pre_cnt = 7'h0;
    end
    next_en_cnt = conv_enable ? ((en_cnt == ACFFC_EN_LAT) ? en_cnt : en_cnt + 2'h1) : 2'h0;
  end
  // toggle half, pulse on every second wrap
  logic half, next_half;
  always_comb begin
    next_half = half;
    next_conv_clk_en = 1'b0;
    if (pre_cnt >= clock_prescale) begin
      next_half = !half;
      next_conv_clk_en = half;
    end
  end
  // flow control
  always_comb begin
    next_sequence_abort = sequence_abort;
    next_sequence_trigger = sequence_trigger;
    next_restart_event = restart_event;
    next_list_load_ok = list_load_ok;
    next_restart_event_err = restart_event_err;
    next_sequence_trigger_err = sequence_trigger_err;
    next_ovr = ovr;
    next_cmd_err = cmd_err;
    next_in_list = in_list;
    next_was_sequence_trigger = was_sequence_trigger;
    next_state = state;
    next_bus_cnt = bus_cnt;
    next_cc_cnt = cc_cnt;
    case (state)
      ACFFC_IDLE: begin
        if (sequence_abort) begin
          next_sequence_abort = 1'b0;
          next_in_list = 1'b0;
        end else if (restart_event) begin
          next_state = ACFFC_LOAD;
        end else if (sequence_trigger) begin
          if (res_bad) begin
            next_cmd_err = 1'b1;
            next_state = ACFFC_HALT;
          end else begin
            next_bus_cnt = ACFFC_RST_BUS;
            next_cc_cnt = ACFFC_PUMP_CC;
            next_was_sequence_trigger = 1'b1;
            next_state = ACFFC_WBUS;
          end
        end
      end
      ACFFC_LOAD: if (cmd_loaded) begin
        next_restart_event = 1'b0;
        next_list_load_ok = 1'b0;
        next_in_list = 1'b1;
        if (trigger_mode) begin
          next_sequence_trigger = 1'b0;
          next_bus_cnt = ACFFC_TRG_BUS;
          next_cc_cnt = 2'h0;
          next_was_sequence_trigger = 1'b1;
          next_state = res_bad ? ACFFC_HALT : ACFFC_WBUS;
          next_cmd_err = res_bad;
        end else begin
          next_state = ACFFC_IDLE;
        end
      end
      ACFFC_WBUS: begin
        if (bus_cnt <= 3'h1) next_state = (cc_cnt == 2'h0) ? ACFFC_CONV : ACFFC_WPUMP;
        next_bus_cnt = bus_cnt - 3'h1;
      end
      ACFFC_WPUMP: if (conv_clk_en_q) begin
        next_cc_cnt = cc_cnt - 2'h1;
        if (cc_cnt == 2'h1) next_state = ACFFC_CONV;
      end
      ACFFC_CONV: begin
        if (was_sequence_trigger) begin
          next_sequence_trigger = 1'b0;
          next_was_sequence_trigger = 1'b0;
        end
        if (conv_done) begin
          if (sequence_abort || end_of_list) begin
            next_state = ACFFC_IDLE;
            next_in_list = !sequence_abort && in_list;
          end else begin
            next_bus_cnt = ACFFC_B2B_BUS;
            next_cc_cnt = ACFFC_PUMP_CC;
            next_state = ACFFC_WBUS;
          end
        end
      end
      ACFFC_HALT: ;
      default: next_state = ACFFC_IDLE;
    endcase
    // requests after the sequencer so a set wins over a same-cycle clear
    if (req_abrt) begin
      if (sequence_abort) next_ovr = 1'b1;
      next_sequence_abort = 1'b1;
    end
    if (req_sequence_trigger) begin
      if (sequence_trigger) next_sequence_trigger_err = 1'b1;
      next_sequence_trigger = 1'b1;
    end
    if (req_restart_event) begin
      if (restart_event) next_ovr = 1'b1;
      next_restart_event = 1'b1;
      next_list_load_ok = req_list_load_ok;
      if (trigger_mode) next_sequence_trigger = 1'b1;
      if (in_list && !sequence_abort && !req_abrt && !end_of_list) begin
        next_sequence_abort = 1'b1;
        next_restart_event_err = 1'b1;
      end
    end
    if (!conv_enable || soft_reset) begin
      next_sequence_abort = 1'b0;
      next_sequence_trigger = 1'b0;
      next_restart_event = 1'b0;
      next_list_load_ok = 1'b0;
      next_state = ACFFC_IDLE;
      next_in_list = 1'b0;
      next_was_sequence_trigger = 1'b0;
      if (soft_reset) next_cmd_err = 1'b0;
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clock_prescale <= ACFFC_PRS_RST;
      pre_cnt <= 7'h0;
      half <= 1'b0;
      conv_clk_en_q <= 1'b0;
      result_justify <= 1'b0;
      resolution_select <= ACFFC_RES_RST;
      en_cnt <= 2'h0;
      sequence_abort <= 1'b0;
      sequence_trigger <= 1'b0;
      restart_event <= 1'b0;
      list_load_ok <= 1'b0;
      cmd_err <= 1'b0;
      restart_event_err <= 1'b0;
      sequence_trigger_err <= 1'b0;
      ovr <= 1'b0;
      in_list <= 1'b0;
      was_sequence_trigger <= 1'b0;
      bus_cnt <= 3'h0;
      cc_cnt <= 2'h0;
      res_q <= 16'h0000;
      state <= ACFFC_IDLE;
    end else if (clk_en) begin
      clock_prescale <= next_clock_prescale;
      pre_cnt <= next_pre_cnt;
      half <= next_half;
      conv_clk_en_q <= next_conv_clk_en;
      result_justify <= next_result_justify;
      resolution_select <= next_resolution_select;
      en_cnt <= next_en_cnt;
      sequence_abort <= next_sequence_abort;
      sequence_trigger <= next_sequence_trigger;
      restart_event <= next_restart_event;
      list_load_ok <= next_list_load_ok;
      cmd_err <= next_cmd_err;
      restart_event_err <= next_restart_event_err;
      sequence_trigger_err <= next_sequence_trigger_err;
      ovr <= next_ovr;
      in_list <= next_in_list;
      was_sequence_trigger <= next_was_sequence_trigger;
      bus_cnt <= next_bus_cnt;
      cc_cnt <= next_cc_cnt;
      res_q <= next_res_q;
      state <= next_state;
    end
  end
  always_comb begin
    case (reg_addr)
      ACFFC_OFS_DIV:  reg_rdata = {1'b0, clock_prescale};
      ACFFC_OFS_FMT:  reg_rdata = {result_justify, 4'h0, resolution_select};
      ACFFC_OFS_FLOW: reg_rdata = {sequence_abort, sequence_trigger, restart_event, list_load_ok, 4'h0};
      default:        reg_rdata = 8'h00;
    endcase
  end
  assign conv_clk_en = conv_clk_en_q;
  assign cmd_load_req = (state == ACFFC_LOAD);
  assign sample_start = (state == ACFFC_CONV) && was_sequence_trigger;
  assign result_word = res_q;
  assign command_error_flag = cmd_err;
  assign restart_error_flag = restart_event_err;
  assign trigger_error_flag = sequence_trigger_err;
  assign overrun_flag = ovr;
  assign converter_idle = (state == ACFFC_IDLE);

  AST_FLOW_CLR: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && !conv_enable |=> (reg_rdata[7:4] == 4'h0 || reg_addr != ACFFC_OFS_FLOW))
    else $error("flow bits not cleared when disabled");
  AST_PRS_LOCK: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && conv_enable && !special_access |=> clock_prescale == $past(clock_prescale))
    else $error("prescale changed while locked");
  AST_FMT_LOCK: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && conv_enable && !special_access |=> resolution_select == $past(resolution_select))
    else $error("format changed while locked");
  AST_SEQUENCE_TRIGGER_ERR: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && conv_enable && !soft_reset && sequence_trigger && req_sequence_trigger |=> sequence_trigger_err)
    else $error("trigger overrun not flagged");
  AST_ABRT_OVR: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && sequence_abort && req_abrt |=> ovr)
    else $error("abort overrun not flagged");
  AST_EN_LAT: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(conv_enable) |-> !flow_ok)
    else $error("flow writable too early");
  AST_CMD_ERR: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && state == ACFFC_IDLE && sequence_trigger && !sequence_abort && !restart_event && res_bad
    && conv_enable && !soft_reset |=> state == ACFFC_HALT && cmd_err)
    else $error("reserved code did not halt");
  AST_CLK_PULSE: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && conv_clk_en |=> !conv_clk_en)
    else $error("conversion clock enable too long");
endmodule

// >>> verif/acffc_core_model.sv
`timescale 1ns/100ps
module acffc_core_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // bench settings
  input  wire logic [3:0]  lat,
  input  wire logic        eol,
  // controller side
  input  wire logic        cmd_load_req,
  input  wire logic        sample_start,
  input  wire logic        converter_idle,
  output logic             cmd_loaded,
  output logic             conv_done,
  output logic             end_of_list,
  output logic      [11:0] raw_result
);
  logic [3:0] cnt;
  logic       busy;
  assign end_of_list = eol;
  // result bus toggles outside conv_done so a stale sample never matches
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt        <= 4'h0;
      busy       <= 1'b0;
      cmd_loaded <= 1'b0;
      conv_done  <= 1'b0;
      raw_result <= 12'h000;
    end else begin
      cmd_loaded <= cmd_load_req && !cmd_loaded && cnt == lat;
      conv_done  <= busy && cnt == lat;
      raw_result <= (busy && cnt == lat) ? 12'habf : ~raw_result;
      cnt        <= (cmd_load_req || busy) && cnt != lat ? cnt + 4'h1 : 4'h0;
      if (sample_start)
        busy <= 1'b1;
      else if (converter_idle || (busy && cnt == lat && eol))
        busy <= 1'b0;
    end
  end
endmodule

// >>> verif/tb_adc_clock_format_flow_control.sv
`timescale 1ns/100ps
module tb_adc_clock_format_flow_control;
  import acffc_pkg::*;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        clk_en = 1'b1;
  logic [2:0]  reg_addr = 3'h0;
  logic        reg_wr = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        conv_enable = 1'b0;
  logic        special_access = 1'b0;
  logic        soft_reset = 1'b0;
  logic        trigger_mode = 1'b0;
  logic [1:0]  access_config = ACFFC_ACC_BUS;
  logic [3:0]  req = 4'h0;
  logic [3:0]  lat = 4'h3;
  logic        eol = 1'b1;
  logic [7:0]  reg_rdata;
  logic [11:0] raw_result;
  logic [15:0] result_word;
  logic        conv_done, end_of_list, cmd_loaded, cmd_load_req, sample_start, conv_clk_en, converter_idle;
  logic        command_error_flag, restart_error_flag, trigger_error_flag, overrun_flag;
  int          err_count = 0;
  int          checks = 0;
  // outputs that the bounded wait can watch, by index
  localparam int W_LOADED = 0, W_IDLE = 1, W_CMDERR = 2, W_DONE = 3, W_SAMPLE = 4, W_CCLK = 5;
  logic [5:0]  watch;
  assign watch = {conv_clk_en, sample_start, conv_done, command_error_flag, converter_idle, cmd_loaded};

  always #25 clock = ~clock;

  acffc_ctrl DUT (.clock, .reset_n, .clk_en, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .conv_enable,
    .special_access, .soft_reset, .trigger_mode, .access_config, .abort_request_line(req[3]),
    .trigger_request_line(req[2]), .restart_request_line(req[1]), .load_ok_request_line(req[0]),
    .conv_done, .end_of_list, .cmd_loaded, .raw_result, .cmd_load_req, .sample_start, .conv_clk_en,
    .result_word, .command_error_flag, .restart_error_flag, .trigger_error_flag, .overrun_flag, .converter_idle);

  acffc_core_model core (.clock, .reset_n, .lat, .eol, .cmd_load_req, .sample_start, .converter_idle,
    .cmd_loaded, .conv_done, .end_of_list, .raw_result);

  task automatic chk(input logic [15:0] got, input logic [15:0] ex);
    checks++;
    if (got !== ex) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, ex);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(negedge clock);
    reg_addr = a;
    #1 chk({8'h00, reg_rdata}, {8'h00, e});
  endtask

  // bounded wait, n is the count of falling edges spent
  task automatic waitfor(input int sel, input int lim, output int n);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (watch[sel] !== 1'b1 && n < lim);
  endtask

  task automatic lp(input logic [3:0] v);
    @(negedge clock);
    req = v;
    @(negedge clock);
    req = 4'h0;
  endtask

  task automatic rst();
    @(negedge clock);
    reset_n = 1'b0;
    conv_enable = 1'b0;
    repeat (4) @(negedge clock);
    reset_n = 1'b1;
  endtask

  task automatic en();
    @(negedge clock);
    conv_enable = 1'b1;
    repeat (4) @(negedge clock);
  endtask

  task automatic t_regs();
    int n;
    rd(ACFFC_OFS_FLOW, 8'h00);
    chk(16'(converter_idle), 16'h1);
    wr(ACFFC_OFS_DIV, 8'h02);
    waitfor(W_CCLK, 20, n);
    waitfor(W_CCLK, 20, n);
    chk(16'(n), 16'h6);
    en();
    wr(ACFFC_OFS_DIV, 8'h05);
    rd(ACFFC_OFS_DIV, 8'h02);
    special_access = 1'b1;
    wr(ACFFC_OFS_DIV, 8'h05);
    rd(ACFFC_OFS_DIV, 8'h05);
    wr(ACFFC_OFS_FMT, 8'h82);
    special_access = 1'b0;
    wr(ACFFC_OFS_FMT, 8'h00);
    rd(ACFFC_OFS_FMT, 8'h82);
  endtask

  task automatic t_flow();
    conv_enable = 1'b0;
    wr(ACFFC_OFS_FLOW, 8'h40);
    rd(ACFFC_OFS_FLOW, 8'h00);
    conv_enable = 1'b1;
    wr(ACFFC_OFS_FLOW, 8'h40);
    rd(ACFFC_OFS_FLOW, 8'h00);
    repeat (3) @(negedge clock);
    wr(ACFFC_OFS_FLOW, 8'h40);
    wr(ACFFC_OFS_FLOW, 8'h00);
    rd(ACFFC_OFS_FLOW, 8'h40);
    wr(ACFFC_OFS_FLOW, 8'h40);
    chk(16'(trigger_error_flag), 16'h1);
    rd(ACFFC_OFS_FLOW, 8'h40);
    conv_enable = 1'b0;
    rd(ACFFC_OFS_FLOW, 8'h00);
  endtask

  task automatic t_conv();
    logic [2:0]  code [3] = '{ACFFC_RES_8, ACFFC_RES_10, ACFFC_RES_12};
    logic [15:0] ex [6] = '{16'hab00, 16'h00ab, 16'habc0, 16'h02af, 16'habf0, 16'h0abf};
    int          n;
    for (int i = 0; i < 6; i++) begin
      conv_enable = 1'b0;
      wr(ACFFC_OFS_FMT, {i[0], 4'h0, code[i/2]});
      en();
      wr(ACFFC_OFS_FLOW, 8'h40);
      waitfor(W_SAMPLE, 30, n);
      chk(16'(n >= 3 && n <= 8), 16'h1);
      rd(ACFFC_OFS_FLOW, 8'h00);
      waitfor(W_DONE, 30, n);
      @(negedge clock);
      chk(result_word, ex[i]);
    end
  endtask

  task automatic t_err();
    int n;
    conv_enable = 1'b0;
    wr(ACFFC_OFS_FMT, 8'h01);
    en();
    wr(ACFFC_OFS_FLOW, 8'h40);
    waitfor(W_CMDERR, 30, n);
    chk(16'(command_error_flag), 16'h1);
    waitfor(W_SAMPLE, 20, n);
    chk(16'(n), 16'h14);
    soft_reset = 1'b1;
    @(negedge clock);
    soft_reset = 1'b0;
    rd(ACFFC_OFS_FLOW, 8'h00);
    chk(16'(command_error_flag), 16'h0);
    conv_enable = 1'b0;
    wr(ACFFC_OFS_FMT, 8'h00);
    en();
  endtask

  task automatic t_abort();
    int n;
    lat = 4'hf;
    eol = 1'b0;
    wr(ACFFC_OFS_FLOW, 8'h40);
    waitfor(W_SAMPLE, 30, n);
    wr(ACFFC_OFS_FLOW, 8'h80);
    wr(ACFFC_OFS_FLOW, 8'h80);
    chk(16'(overrun_flag), 16'h1);
    rd(ACFFC_OFS_FLOW, 8'h80);
    waitfor(W_IDLE, 80, n);
    rd(ACFFC_OFS_FLOW, 8'h00);
    wr(ACFFC_OFS_FLOW, 8'h20);
    @(negedge clock);
    chk(16'(cmd_load_req), 16'h1);
    waitfor(W_LOADED, 40, n);
    @(negedge clock);
    rd(ACFFC_OFS_FLOW, 8'h00);
    chk(16'(restart_error_flag), 16'h0);
    wr(ACFFC_OFS_FLOW, 8'h40);
    waitfor(W_SAMPLE, 30, n);
    wr(ACFFC_OFS_FLOW, 8'h20);
    @(negedge clock);
    #1 chk(16'(reg_rdata[7]), 16'h1);
    chk(16'(restart_error_flag), 16'h1);
  endtask

  task automatic t_mode();
    int n;
    rst();
    trigger_mode = 1'b1;
    lat = 4'h6;
    eol = 1'b1;
    en();
    wr(ACFFC_OFS_FLOW, 8'h20);
    rd(ACFFC_OFS_FLOW, 8'h60);
    n = 0;
    while (reg_rdata[6:5] == 2'b11 && n < 40) begin
      @(negedge clock);
      n++;
    end
    chk({14'h0, reg_rdata[6:5]}, 16'h0);
    waitfor(W_SAMPLE, 20, n);
    chk(16'(n >= 4 && n <= 6), 16'h1);
  endtask

  task automatic t_lines();
    rst();
    trigger_mode = 1'b0;
    access_config = ACFFC_ACC_INT;
    wr(ACFFC_OFS_DIV, 8'h7f);
    en();
    wr(ACFFC_OFS_FLOW, 8'h40);
    rd(ACFFC_OFS_FLOW, 8'h00);
    lp(4'h4);
    rd(ACFFC_OFS_FLOW, 8'h40);
    lp(4'h4);
    chk(16'(trigger_error_flag), 16'h1);
    lp(4'h8);
    lp(4'h8);
    chk(16'(overrun_flag), 16'h1);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    rst();
    t_regs();
    t_flow();
    rst();
    t_conv();
    t_err();
    t_abort();
    t_mode();
    t_lines();
    summarize();
  end

  // whole run needs under a thousand cycles; allow twenty thousand
  initial begin
    #1000000;
    err_count++;
    summarize();
  end
endmodule
